// file: hw/ctu_consts.svh
/*
  constants for the charge time unit control register one block.
  assumes: included by bare name from ctu_ctrl_one only; the package and ctu_edge_sync do not include it.
*/
`ifndef CTU_CONSTS_SVH
`define CTU_CONSTS_SVH
// ================================================================
// register map
`define CTU_ADDR_W        4
`define CTU_CTRL_ONE_ADDR 4'h0
`define CTU_STATUS_ADDR   4'h1
`define CTU_EDGE_SW_ADDR  4'h2
// ================================================================
// control register one field positions
`define CTU_BIT_ENABLE    15
`define CTU_BIT_SIDL      13
`define CTU_BIT_TIMEGEN   12
`define CTU_BIT_HWEDGE    11
`define CTU_BIT_SEQ       10
`define CTU_BIT_DISCH     9
`define CTU_BIT_TRIG      8
`define CTU_CTRL_MASK     16'hbf00
`define CTU_CTRL_RESET    16'h0000
// ================================================================
// edge status register field positions
`define CTU_BIT_EDGE1     0
`define CTU_BIT_EDGE2     1
`define CTU_BIT_RUNNING   2
`define CTU_BIT_PULSE     3
`endif

// file: hw/ctu_pkg.sv
/*
  types for the charge time unit control register one block.
  assumes: the constants header sits beside it.
*/
package ctu_pkg;
  // ================================================================
  // measurement sequencer states
  typedef enum logic [1:0] {
    CTU_IDLE  = 2'b00,
    CTU_WAIT2 = 2'b01,
    CTU_DONE  = 2'b10
  } ctu_state_t;
endpackage

// file: hw/ctu_edge_sync.sv
/*
  two flip-flop synchroniser plus rising edge detector for hardware edges.
  assumes: one clock, clock enable freezes state.
*/
`timescale 1ns/1ns
module ctu_edge_sync
  import ctu_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] rise
);
  // ================================================================
  // state
  typedef struct packed {
    logic [WIDTH-1:0] meta;   // first stage, read only by second
    logic [WIDTH-1:0] sync;   // second stage
    logic [WIDTH-1:0] prev;   // delayed copy for edges
  } ctu_sync_t;
  ctu_sync_t st;
  ctu_sync_t next_st;

  // next state
  always_comb begin
    next_st      = st;
    next_st.meta = async_in;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  // register stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // one pulse per rising edge
  assign rise = st.sync & ~st.prev;
endmodule

// file: hw/ctu_ctrl_one.sv
/*
  control register one of a charge time unit with its edge sequencer.
  assumes: plain register port, read data one cycle after read strobe,
  hardware edge sources arrive asynchronous from pins or other clocks.
*/
// Chosen here: the plain strobed port and the address map.
// Functional notes
// - unit works only while enable bit set, except the discharge output, which follows its bit regardless
// - stop in idle halts unit in idle
// - time generation bit enables pulse generation
// - edge enable one takes hardware edges
// - edge enable zero uses software writes to the edge software register
// - sequence bit requires edge one before two
// - discharge bit grounds current source output
`timescale 1ns/1ns
`include "ctu_consts.svh"
module ctu_ctrl_one
  import ctu_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  input  wire logic [`CTU_ADDR_W-1:0] addr,
  input  wire logic [15:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [15:0]            rdata,
  input  wire logic                   cpu_idle,
  input  wire logic                   hw_edge1,
  input  wire logic                   hw_edge2,
  output logic                        source_ground,
  output logic                        current_on,
  output logic                        pulse_out,
  output logic                        conv_trigger
);
  // ================================================================
  // state
  typedef struct packed {
    logic [15:0] ctrl;       // control register one
    logic        edge1;      // edge one status
    logic        edge2;      // edge two status
    ctu_state_t  seq;        // sequencer state
    logic [15:0] rdata;      // read data
    logic        ground;     // discharge output
    logic        current;    // current source steering
    logic        pulse;      // pulse output
    logic        trig;       // conversion trigger pulse
  } ctu_regs_t;
  ctu_regs_t st;
  ctu_regs_t next_st;

  logic [1:0] hw_rise;       // synchronised hardware edges
  logic       running;       // unit active this cycle
  logic       ev1;           // accepted edge one event
  logic       ev2;           // accepted edge two event
  logic [15:0] status_word;  // edge status read view

  // ================================================================
  // hardware edge synchroniser
  ctu_edge_sync #(
    .WIDTH    (2)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .async_in ({hw_edge2, hw_edge1}),
    .rise     (hw_rise)
  );

  // unit runs when enabled and not stopped by idle
  assign running = st.ctrl[`CTU_BIT_ENABLE]
                   & ~(st.ctrl[`CTU_BIT_SIDL] & cpu_idle);

  // edge events only from hardware when edge enable is set
  assign ev1 = running & st.ctrl[`CTU_BIT_HWEDGE] & hw_rise[0];
  // edge two blocked until edge one when sequencing is on
  assign ev2 = running & st.ctrl[`CTU_BIT_HWEDGE] & hw_rise[1]
               & (~st.ctrl[`CTU_BIT_SEQ] | st.edge1);

  // status view
  always_comb begin
    status_word                    = 16'h0000;
    status_word[`CTU_BIT_EDGE1]   = st.edge1;
    status_word[`CTU_BIT_EDGE2]   = st.edge2;
    status_word[`CTU_BIT_RUNNING] = running;
    status_word[`CTU_BIT_PULSE]   = st.pulse;
  end

  // ================================================================
  // next state
  always_comb begin
    next_st       = st;
    next_st.trig  = 1'b0;
    // register write
    if (wr && addr == `CTU_CTRL_ONE_ADDR) begin
      next_st.ctrl = wdata & `CTU_CTRL_MASK;
    end
    // software edges only when hardware edges are off
    if (wr && addr == `CTU_EDGE_SW_ADDR && running
        && !st.ctrl[`CTU_BIT_HWEDGE]) begin
      if (wdata[`CTU_BIT_EDGE1]) begin
        next_st.edge1 = 1'b1;
      end
      if (wdata[`CTU_BIT_EDGE2]
          && (!st.ctrl[`CTU_BIT_SEQ] || st.edge1)) begin
        next_st.edge2 = 1'b1;
      end
    end else if (wr && addr == `CTU_STATUS_ADDR) begin
      // write zero clears a status bit, edge set wins below
      next_st.edge1 = st.edge1 & wdata[`CTU_BIT_EDGE1];
      next_st.edge2 = st.edge2 & wdata[`CTU_BIT_EDGE2];
    end
    // hardware edges set status, winning over clear
    if (ev1) begin
      next_st.edge1 = 1'b1;
    end
    if (ev2) begin
      next_st.edge2 = 1'b1;
    end
    // disabled unit clears its edge state
    if (!st.ctrl[`CTU_BIT_ENABLE]) begin
      next_st.edge1 = 1'b0;
      next_st.edge2 = 1'b0;
    end
    // sequencer: current flows between edge one and edge two
    case (st.seq)
      CTU_IDLE: begin
        if (running && next_st.edge1 && !next_st.edge2) begin
          next_st.seq = CTU_WAIT2;
        end
      end
      CTU_WAIT2: begin
        if (!running) begin
          next_st.seq = CTU_IDLE;
        end else if (next_st.edge2) begin
          next_st.seq  = CTU_DONE;
          next_st.trig = st.ctrl[`CTU_BIT_TRIG];
        end
      end
      CTU_DONE: begin
        if (!next_st.edge1 && !next_st.edge2) begin
          next_st.seq = CTU_IDLE;
        end
      end
      default: begin
        next_st.seq = CTU_IDLE;
      end
    endcase
    next_st.current = running && next_st.seq == CTU_WAIT2;
    // pulse generation only with time generation on; software must
    // route the first comparator to edge two or no pulse ever ends
    next_st.pulse  = running && st.ctrl[`CTU_BIT_TIMEGEN]
                     && next_st.seq == CTU_WAIT2;
    next_st.ground = st.ctrl[`CTU_BIT_DISCH];
    // read port, unmapped reads zero
    next_st.rdata = 16'h0000;
    if (rd) begin
      case (addr)
        `CTU_CTRL_ONE_ADDR: next_st.rdata = st.ctrl & `CTU_CTRL_MASK;
        `CTU_STATUS_ADDR:   next_st.rdata = status_word;
        default:            next_st.rdata = 16'h0000;
      endcase
    end
  end

  // ================================================================
  // register stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st      <= '0;
      st.ctrl <= `CTU_CTRL_RESET;
      st.seq  <= CTU_IDLE;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign rdata         = st.rdata;
  assign source_ground = st.ground;
  assign current_on    = st.current;
  assign pulse_out     = st.pulse;
  assign conv_trigger  = st.trig;
endmodule

// file: dv/ctu_ctrl_one_props.sv
/* checker for the ctu_ctrl_one ports.
   assumes: bound below, one clock, reset_n low disables. */
`timescale 1ns/1ns
module ctu_ctrl_one_props (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        source_ground,
  input wire logic        current_on,
  input wire logic        pulse_out,
  input wire logic        conv_trigger
);
  // ================================================================
  // port checks
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_RDATA_IDLE: assert property (
    $past(clk_en) && !$past(rd) |-> rdata == 16'h0)
    else $error("read data not idle");
  AST_RDATA_UNUSED: assert property (
    $past(rd) && $past(addr) == 4'h0 |-> (rdata & 16'h40ff) == 16'h0)
    else $error("unused bits set");
  AST_GROUND: assert property (
    wr && clk_en && addr == 4'h0 ##1 clk_en |=> source_ground == $past(wdata[9], 2))
    else $error("ground bit not applied");
  AST_GROUND_CAUSE: assert property (
    $changed(source_ground) |-> $past(wr, 2) && $past(addr, 2) == 4'h0)
    else $error("ground moved alone");
  AST_PULSE_GATE: assert property (
    pulse_out |-> current_on)
    else $error("pulse without current");
  AST_TRIG_ONE: assert property (
    conv_trigger && clk_en |=> !conv_trigger)
    else $error("trigger too long");
  AST_TRIG_END: assert property (
    conv_trigger |-> !current_on)
    else $error("trigger while running");
  AST_OFF: assert property (
    wr && clk_en && addr == 4'h0 && !wdata[15] ##1 clk_en |=> !current_on && !pulse_out)
    else $error("disabled unit active");
endmodule
bind ctu_ctrl_one ctu_ctrl_one_props ctu_ctrl_one_props_inst (
  .clk, .reset_n, .clk_en, .addr, .wdata, .wr, .rd, .rdata,
  .source_ground, .current_on, .pulse_out, .conv_trigger
);

// file: dv/charge_timer_control_reg_one_tb.sv
/* self-checking bench for ctu_ctrl_one.
   assumes: package, design and checker compiled first. */
`timescale 1ns/1ns
module charge_timer_control_reg_one_tb import ctu_pkg::*; ;
  logic        clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
  logic        wr = 1'b0, rd = 1'b0, cpu_idle = 1'b0;
  logic        hw_edge1 = 1'b0, hw_edge2 = 1'b0, seen;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0, rdata, d;
  logic        source_ground, current_on, pulse_out, conv_trigger;
  // index one runs time generation, edge two taken as the comparator
  logic [15:0] ctl [7] = '{16'h8800, 16'h9800, 16'h0800, 16'ha800,
                           16'h8800, 16'h8000, 16'h8000};
  logic [6:0]  idl = 7'b0011000, on = 7'b1010011;
  int          num_errors = 0, tests_run = 0, cycles = 0;
  ctu_ctrl_one ctu_ctrl_one_inst (
    .clk, .reset_n, .clk_en, .addr, .wdata, .wr, .rd, .rdata, .cpu_idle,
    .hw_edge1, .hw_edge2, .source_ground, .current_on, .pulse_out, .conv_trigger
  );
  // ================================================================
  // clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ================================================================
  // shared tasks
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, e);
  endtask
  // disable first so old status is gone, then arm and clear status
  task automatic arm(input logic [15:0] c, input logic i);
    wr_reg(4'h0, 16'h0);
    wr_reg(4'h0, c);
    wr_reg(4'h1, 16'h0);
    cpu_idle <= i;
  endtask
  task automatic pulse(input logic [1:0] w);
    @(posedge clk);
    hw_edge1 <= w[0];
    hw_edge2 <= w[1];
    repeat (4) @(posedge clk);
    hw_edge1 <= 1'b0;
    hw_edge2 <= 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // ================================================================
  // main sequence
  initial begin
    d = 16'($urandom(9026));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(4'h0, 16'h0);
    rd_chk(4'hf, 16'h0);
    $display("test reset done");
    repeat (24) begin
      d = 16'($urandom());
      wr_reg(4'h0, d);
      rd_chk(4'h0, d & 16'hbf00);
      check(16'(source_ground), 16'(d[9]));
      rd_chk(4'(3 + $urandom() % 13), 16'h0);
    end
    $display("test register done");
    for (int i = 0; i < 7; i++) begin
      arm(ctl[i], idl[i]);
      if (i == 6) wr_reg(4'h2, 16'h1);
      else pulse(2'b01);
      repeat (3) @(negedge clk);
      check(16'(current_on), 16'(on[i]));
      check(16'(pulse_out), 16'(on[i] & ctl[i][12]));
    end
    $display("test modes done");
    arm(16'h8c00, 1'b0);
    pulse(2'b10);
    rd_chk(4'h1, 16'h0004);
    arm(16'h8800, 1'b0);
    pulse(2'b10);
    rd_chk(4'h1, 16'h0006);
    wr_reg(4'h2, 16'h0001);
    rd_chk(4'h1, 16'h0006);
    arm(16'h8400, 1'b0);
    wr_reg(4'h2, 16'h0002);
    rd_chk(4'h1, 16'h0004);
    wr_reg(4'h2, 16'h0001);
    wr_reg(4'h2, 16'h0002);
    rd_chk(4'h1, 16'h0007);
    wr_reg(4'h1, 16'h0001);
    rd_chk(4'h1, 16'h0005);
    $display("test order done");
    for (int t = 0; t < 2; t++) begin
      arm(t ? 16'h8900 : 16'h8800, 1'b0);
      pulse(2'b01);
      seen = 1'b0;
      @(posedge clk);
      hw_edge2 <= 1'b1;
      repeat (8) @(negedge clk) seen |= conv_trigger;
      check(16'(seen), 16'(t));
      check(16'(current_on), 16'h0);
      @(posedge clk);
      hw_edge2 <= 1'b0;
    end
    $display("test trigger done");
    // frozen clock enable holds read data and drops a write strobe
    arm(16'h8000, 1'b0);
    @(posedge clk);
    addr <= 4'h0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    clk_en <= 1'b0;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(negedge clk);
    check(rdata, 16'h8000);
    @(posedge clk);
    clk_en <= 1'b1;
    rd_chk(4'h0, 16'h8000);
    $display("test freeze done");
    give_verdict();
  end
endmodule
